// File: rtl/cawp_pkg.sv
// Package with register map, field positions and constants for the counter array
package cawp_pkg;
	// ------------------------------------------------------------
	// Register addresses on the special-function-register bus
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_COUNTER_MODE  = 8'hd9;
	localparam logic [7:0] ADDR_MODULE_MODE   = 8'hdc;
	localparam logic [7:0] ADDR_COMPARE_LOW   = 8'hfb;
	localparam logic [7:0] ADDR_COMPARE_HIGH  = 8'hfc;
	localparam logic [7:0] ADDR_COUNT_LOW     = 8'hf9;
	localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hfa;
	localparam logic [7:0] ADDR_STATUS        = 8'hd8;

	// ------------------------------------------------------------
	// Counter mode register fields
	// ------------------------------------------------------------
	localparam int CM_IDLE_SUSPEND   = 7;
	localparam int CM_WATCHDOG_SEL   = 6;
	localparam int CM_WATCHDOG_LOCK  = 5;
	localparam int CM_SOURCE_LSB     = 1;
	localparam int CM_OVF_IRQ_EN     = 0;
	localparam logic [7:0] CM_RESET  = 8'h40;
	localparam logic [7:0] CM_WMASK  = 8'hef;

	// ------------------------------------------------------------
	// Module mode register fields
	// ------------------------------------------------------------
	localparam int MM_WIDE_PWM       = 7;
	localparam int MM_COMP_EN        = 6;
	localparam int MM_MATCH_EN       = 3;
	localparam int MM_PWM_EN         = 1;
	localparam int MM_CAP_IRQ_EN     = 0;
	localparam logic [7:0] MM_RESET  = 8'h00;

	// Status register: bit 7 overflow flag, bit 0 compare flag
	localparam int ST_OVF_FLAG       = 7;
	localparam int ST_CMP_FLAG       = 0;

	// ------------------------------------------------------------
	// Count sources and divider counts
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_DIV12 = 3'h0,
		SRC_DIV4  = 3'h1,
		SRC_T0OVF = 3'h2,
		SRC_EXTIN = 3'h3,
		SRC_SYS   = 3'h4,
		SRC_EXT8  = 3'h5
	} cawp_src_t;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [3:0] DIV8_LAST  = 4'h7;
endpackage : cawp_pkg

// File: rtl/cawp_tick_if.sv
// Interface carrying the count tick from the source selector to the counter
`timescale 1ns/1ps
interface cawp_tick_if;
	logic       tick;
	logic [2:0] source;
	logic       suspend;
	modport gen (output tick, input source, input suspend);
	modport use_side (input tick, output source, output suspend);
endinterface : cawp_tick_if

// File: rtl/cawp_tick_gen.sv
// Count source selection and prescaling for the counter array
`timescale 1ns/1ps
module cawp_tick_gen (
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  timer0_ovf,
	input  wire logic  ext_count_in,
	input  wire logic  ext_clk_in,
	cawp_tick_if.gen   tk
);
	logic [3:0] pre_reg;
	logic [3:0] pre_next;
	logic [1:0] ecin_sync_reg;
	logic       ecin_old_reg;
	logic [1:0] eclk_sync_reg;
	logic       eclk_old_reg;
	logic [2:0] eclk_cnt_reg;
	logic       tick_reg;
	logic       tick_next;
	wire        pre_wrap;
	wire  [3:0] pre_last;
	wire        ecin_fall;
	wire        eclk_rise;
	wire        eclk_tick;

	assign pre_last = (tk.source == cawp_pkg::SRC_DIV12) ?
		cawp_pkg::DIV12_LAST : cawp_pkg::DIV4_LAST;
	assign pre_wrap  = (pre_reg >= pre_last);
	assign pre_next  = pre_wrap ? 4'h0 : pre_reg + 4'h1;
	assign ecin_fall = ecin_old_reg & ~ecin_sync_reg[1];
	assign eclk_rise = ~eclk_old_reg & eclk_sync_reg[1];
	assign eclk_tick = eclk_rise && (eclk_cnt_reg == cawp_pkg::DIV8_LAST[2:0]);

	always_comb begin
		unique case (tk.source)
			cawp_pkg::SRC_DIV12: tick_next = pre_wrap;
			cawp_pkg::SRC_DIV4:  tick_next = pre_wrap;
			cawp_pkg::SRC_T0OVF: tick_next = timer0_ovf;
			cawp_pkg::SRC_EXTIN: tick_next = ecin_fall;
			cawp_pkg::SRC_SYS:   tick_next = 1'b1;
			cawp_pkg::SRC_EXT8:  tick_next = eclk_tick;
			default:             tick_next = 1'b0;
		endcase
	end
	assign tk.tick = tick_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_reg       <= 4'h0;
			ecin_sync_reg <= 2'h3;
			ecin_old_reg  <= 1'b1;
			eclk_sync_reg <= 2'h0;
			eclk_old_reg  <= 1'b0;
			eclk_cnt_reg  <= 3'h0;
			tick_reg      <= 1'b0;
		end else begin
			ecin_sync_reg <= {ecin_sync_reg[0], ext_count_in};
			ecin_old_reg  <= ecin_sync_reg[1];
			eclk_sync_reg <= {eclk_sync_reg[0], ext_clk_in};
			eclk_old_reg  <= eclk_sync_reg[1];
			// Idle suspend freezes prescaler and holds tick low
			if (!tk.suspend) begin
				pre_reg  <= pre_next;
				tick_reg <= tick_next;
				if (eclk_rise)
					eclk_cnt_reg <= eclk_cnt_reg + 3'h1;
			end else begin
				tick_reg <= 1'b0;
			end
		end
	end
endmodule : cawp_tick_gen

// File: rtl/cawp_top.sv
// Counter array with one wide-PWM compare module and mode registers
//
// Behaviour
// - Compare value sets low time per period
// - Counter match drives output high
// - Counter overflow drives output low unless compare is zero
// - Wide PWM needs enable, PWM, wide bits
// - Low write clears enable, high sets
// - High fraction is (65536-compare)/65536
// - Enable cleared gives constant low output
// - Idle-suspend bit stops array during idle
// - Watchdog select makes module 2 watchdog
// - Lock keeps watchdog select until reset
// - Three-bit count source selection
`timescale 1ns/1ps
module cawp_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        sfr_we,
	input  wire logic        sfr_re,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        cpu_idle,
	input  wire logic        timer0_ovf,
	input  wire logic        ext_count_in,
	input  wire logic        ext_clk_in,
	output logic             pwm_output_pin,
	output logic             overflow_irq,
	output logic             match_irq,
	output logic             watchdog_active
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]  counter_mode_reg;
	logic [7:0]  module_mode_reg;
	logic [15:0] compare_value_reg;
	logic [15:0] count_reg;
	logic        overflow_flag_reg;
	logic        compare_flag_reg;
	logic        pwm_reg;
	logic        ovf_irq_reg;
	logic        match_irq_reg;
	logic        wdog_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;

	cawp_tick_if tk ();

	cawp_tick_gen u_tick (
		.clk          (clk),
		.rstn         (rstn),
		.timer0_ovf   (timer0_ovf),
		.ext_count_in (ext_count_in),
		.ext_clk_in   (ext_clk_in),
		.tk           (tk)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire wr_cmode  = sfr_we && (sfr_addr == cawp_pkg::ADDR_COUNTER_MODE);
	wire wr_mmode  = sfr_we && (sfr_addr == cawp_pkg::ADDR_MODULE_MODE);
	wire wr_cmp_lo = sfr_we && (sfr_addr == cawp_pkg::ADDR_COMPARE_LOW);
	wire wr_cmp_hi = sfr_we && (sfr_addr == cawp_pkg::ADDR_COMPARE_HIGH);
	wire wr_stat   = sfr_we && (sfr_addr == cawp_pkg::ADDR_STATUS);
	wire wr_cnt_lo = sfr_we && (sfr_addr == cawp_pkg::ADDR_COUNT_LOW);
	wire wr_cnt_hi = sfr_we && (sfr_addr == cawp_pkg::ADDR_COUNT_HIGH);

	wire idle_suspend    = counter_mode_reg[cawp_pkg::CM_IDLE_SUSPEND];
	wire watchdog_select = counter_mode_reg[cawp_pkg::CM_WATCHDOG_SEL];
	wire watchdog_lock   = counter_mode_reg[cawp_pkg::CM_WATCHDOG_LOCK];
	wire overflow_irq_enable = counter_mode_reg[cawp_pkg::CM_OVF_IRQ_EN];
	wire comparator_enable   = module_mode_reg[cawp_pkg::MM_COMP_EN];
	wire pwm_enable_bit      = module_mode_reg[cawp_pkg::MM_PWM_EN];
	wire wide_pwm_select     = module_mode_reg[cawp_pkg::MM_WIDE_PWM];
	wire match_enable        = module_mode_reg[cawp_pkg::MM_MATCH_EN];
	wire capture_flag_irq_enable = module_mode_reg[cawp_pkg::MM_CAP_IRQ_EN];

	wire wide_pwm_on = comparator_enable && pwm_enable_bit && wide_pwm_select;

	assign tk.source  = counter_mode_reg[cawp_pkg::CM_SOURCE_LSB +: 3];
	// Suspend only when selected and idling
	assign tk.suspend = idle_suspend && cpu_idle;

	wire        tick     = tk.tick;
	wire        ovf_now  = tick && (count_reg == 16'hffff);
	// Match on the tick that takes the counter to the compare value
	wire        match_now = tick && ((count_reg + 16'h0001) == compare_value_reg);

	// Mode writes blocked while watchdog selected
	wire        cmode_take = wr_cmode && !watchdog_select;
	// Lock holds watchdog select until reset
	wire        wdog_next_bit = (watchdog_lock && watchdog_select) ? 1'b1 :
		sfr_wdata[cawp_pkg::CM_WATCHDOG_SEL];
	wire [7:0]  cmode_wr_val = {sfr_wdata[7], wdog_next_bit, sfr_wdata[5:0]}
		& cawp_pkg::CM_WMASK;
	// Only the select bit responds while selected; unlocked it takes the written bit 6
	wire        cmode_wd_set = wr_cmode && watchdog_select;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		unique case (sfr_addr)
			cawp_pkg::ADDR_COUNTER_MODE: rdata_next = counter_mode_reg;
			cawp_pkg::ADDR_MODULE_MODE:  rdata_next = module_mode_reg;
			cawp_pkg::ADDR_COMPARE_LOW:  rdata_next = compare_value_reg[7:0];
			cawp_pkg::ADDR_COMPARE_HIGH: rdata_next = compare_value_reg[15:8];
			cawp_pkg::ADDR_COUNT_LOW:    rdata_next = count_reg[7:0];
			cawp_pkg::ADDR_COUNT_HIGH:   rdata_next = count_reg[15:8];
			cawp_pkg::ADDR_STATUS: rdata_next = {overflow_flag_reg, 6'h00,
				compare_flag_reg};
			default:                     rdata_next = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Mode and compare registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			counter_mode_reg <= cawp_pkg::CM_RESET;
		end else if (cmode_take) begin
			counter_mode_reg <= cmode_wr_val;
		end else if (cmode_wd_set) begin
			counter_mode_reg[cawp_pkg::CM_WATCHDOG_SEL] <= wdog_next_bit;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			module_mode_reg   <= cawp_pkg::MM_RESET;
			compare_value_reg <= 16'h0000;
		end else begin
			if (wr_mmode)
				module_mode_reg <= sfr_wdata;
			if (wr_cmp_lo) begin
				compare_value_reg[7:0] <= sfr_wdata;
				module_mode_reg[cawp_pkg::MM_COMP_EN] <= 1'b0;
			end
			if (wr_cmp_hi) begin
				compare_value_reg[15:8] <= sfr_wdata;
				module_mode_reg[cawp_pkg::MM_COMP_EN] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Counter and flags
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg         <= 16'h0000;
			overflow_flag_reg <= 1'b0;
			compare_flag_reg  <= 1'b0;
		end else begin
			// Software writes to the counter win over a tick
			if (wr_cnt_lo)
				count_reg[7:0] <= sfr_wdata;
			else if (wr_cnt_hi)
				count_reg[15:8] <= sfr_wdata;
			else if (tick)
				count_reg <= count_reg + 16'h0001;
			// Hardware set wins over a software clear in the same cycle
			if (ovf_now)
				overflow_flag_reg <= 1'b1;
			else if (wr_stat && !sfr_wdata[cawp_pkg::ST_OVF_FLAG])
				overflow_flag_reg <= 1'b0;
			if (match_now && wide_pwm_on && match_enable)
				compare_flag_reg <= 1'b1;
			else if (wr_stat && !sfr_wdata[cawp_pkg::ST_CMP_FLAG])
				compare_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// PWM output and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwm_reg <= 1'b0;
		end else if (!wide_pwm_on) begin
			pwm_reg <= 1'b0;
		end else if (match_now) begin
			// Match sets output; compare zero keeps it high
			pwm_reg <= 1'b1;
		end else if (ovf_now) begin
			// Overflow clears output; low time = compare
			pwm_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ovf_irq_reg   <= 1'b0;
			match_irq_reg <= 1'b0;
			wdog_reg      <= 1'b0;
			rdata_reg     <= 8'h00;
		end else begin
			ovf_irq_reg   <= overflow_flag_reg && overflow_irq_enable;
			// Match interrupt lets software pace updates
			match_irq_reg <= compare_flag_reg && capture_flag_irq_enable;
			// Module 2 runs as watchdog when selected
			wdog_reg      <= watchdog_select;
			if (sfr_re)
				rdata_reg <= rdata_next;
		end
	end

	assign pwm_output_pin  = pwm_reg;
	assign overflow_irq    = ovf_irq_reg;
	assign match_irq       = match_irq_reg;
	assign watchdog_active = wdog_reg;
	assign sfr_rdata       = rdata_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_match_sets_pin: assert property (@(posedge clk) disable iff (!rstn)
		(match_now && wide_pwm_on) |=> pwm_output_pin)
		else $error("pin not high after match");
	chk_ovf_clears_pin: assert property (@(posedge clk) disable iff (!rstn)
		(ovf_now && !match_now) |=> !pwm_output_pin)
		else $error("pin not low after overflow");
	chk_off_is_low: assert property (@(posedge clk) disable iff (!rstn)
		!$past(wide_pwm_on) |-> !pwm_output_pin)
		else $error("pin high with pwm off");
	chk_gate_bits: assert property (@(posedge clk) disable iff (!rstn)
		pwm_output_pin |-> $past(comparator_enable && pwm_enable_bit
		&& wide_pwm_select))
		else $error("pin high without mode bits");
	chk_low_clears_en: assert property (@(posedge clk) disable iff (!rstn)
		(wr_cmp_lo && !wr_cmp_hi) |=> !comparator_enable)
		else $error("low write left enable set");
	chk_high_sets_en: assert property (@(posedge clk) disable iff (!rstn)
		wr_cmp_hi |=> comparator_enable)
		else $error("high write left enable clear");
	chk_lock_holds_wd: assert property (@(posedge clk) disable iff (!rstn)
		(watchdog_lock && watchdog_select) |=> watchdog_select)
		else $error("locked watchdog select cleared");
	chk_wd_blocks_wr: assert property (@(posedge clk) disable iff (!rstn)
		(wr_cmode && watchdog_select) |=>
		$stable({counter_mode_reg[7], counter_mode_reg[5:0]}))
		else $error("mode changed while watchdog selected");
	chk_ovf_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
		overflow_irq |-> $past(overflow_irq_enable))
		else $error("overflow interrupt while masked");
	chk_idle_freeze: assert property (@(posedge clk) disable iff (!rstn)
		(idle_suspend && cpu_idle) ##1 (idle_suspend && cpu_idle)
		|=> $stable(count_reg))
		else $error("counter ran during idle suspend");
endmodule : cawp_top

// File: dv/cawp_load_model.sv
// Load on the PWM output pin: counts edges and times the high pulses
`timescale 1ns/1ps
module cawp_load_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin,
	output int        rises,
	output int        falls,
	output int        high_len
);
	// ------------------------------------------------------------
	// Edge counting and pulse timing
	// ------------------------------------------------------------
	logic pin_last;
	int   run;

	// Lengths are in clk cycles, so tick counts must be scaled by TICK to compare
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_last <= 1'b0;
			run      <= 0;
			rises    <= 0;
			falls    <= 0;
			high_len <= 0;
		end else begin
			pin_last <= pin;
			if (pin && !pin_last) begin
				rises <= rises + 1;
				run   <= 1;
			end else if (pin) begin
				run <= run + 1;
			end
			if (!pin && pin_last) begin
				falls    <= falls + 1;
				high_len <= run;
			end
		end
	end
endmodule : cawp_load_model

// File: dv/tb_cawp_top.sv
// Self-checking bench for the counter array with a wide-PWM module
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
	end \
end
module tb_cawp_top;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam int TICK = 12;
	logic       clk;
	logic       rstn;
	logic       sfr_we;
	logic       sfr_re;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       cpu_idle;
	logic       pwm_output_pin;
	logic       overflow_irq;
	logic       match_irq;
	logic       watchdog_active;
	int         rises;
	int         falls;
	int         high_len;
	int         mismatches;
	int         cmp_count;
	logic [7:0] d0;
	logic [7:0] d1;
	int         r0;

	cawp_top i_cawp_top (
		.clk            (clk),
		.rstn           (rstn),
		.sfr_we         (sfr_we),
		.sfr_re         (sfr_re),
		.sfr_addr       (sfr_addr),
		.sfr_wdata      (sfr_wdata),
		.sfr_rdata      (sfr_rdata),
		.cpu_idle       (cpu_idle),
		.timer0_ovf     (1'b0),
		.ext_count_in   (1'b0),
		.ext_clk_in     (1'b0),
		.pwm_output_pin (pwm_output_pin),
		.overflow_irq   (overflow_irq),
		.match_irq      (match_irq),
		.watchdog_active(watchdog_active)
	);

	cawp_load_model i_cawp_load_model (
		.clk     (clk),
		.rstn    (rstn),
		.pin     (pwm_output_pin),
		.rises   (rises),
		.falls   (falls),
		.high_len(high_len)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Register access and helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_we    = 1'b1;
		sfr_addr  = a;
		sfr_wdata = d;
		@(negedge clk);
		sfr_we = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_re   = 1'b1;
		sfr_addr = a;
		@(negedge clk);
		sfr_re = 1'b0;
		d      = sfr_rdata;
	endtask : rd

	// Bounded wait for a pin level; a timeout shows as a mismatch
	task automatic wait_pin(input logic v, input int lim);
		int n;
		n = 0;
		while (pwm_output_pin !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		`CHK("pin level", v, pwm_output_pin)
	endtask : wait_pin

	// Count written high byte first so the low byte lands exactly
	task automatic set_count(input logic [7:0] lo);
		wr(cawp_pkg::ADDR_COUNT_HIGH, 8'hff);
		wr(cawp_pkg::ADDR_COUNT_LOW, lo);
	endtask : set_count

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#80000;
		mismatches++;
		final_report();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		mismatches = 0;
		cmp_count  = 0;
		rstn       = 1'b0;
		sfr_we     = 1'b0;
		sfr_re     = 1'b0;
		sfr_addr   = 8'h00;
		sfr_wdata  = 8'h00;
		cpu_idle   = 1'b0;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("watchdog_active", 1'b1, watchdog_active)
		rd(cawp_pkg::ADDR_COUNTER_MODE, d0);
		`CHK("counter mode reset", cawp_pkg::CM_RESET, d0)
		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h8f);
		rd(cawp_pkg::ADDR_COUNTER_MODE, d0);
		`CHK("mode write ignored", 8'h00, d0)
		rd(8'h00, d0);
		`CHK("unmapped read", 8'h00, d0)
		$display("test mode register done");

		// Idle suspend set: counter frozen while idling
		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h80);
		cpu_idle = 1'b1;
		rd(cawp_pkg::ADDR_COUNT_LOW, d0);
		repeat (50) @(negedge clk);
		rd(cawp_pkg::ADDR_COUNT_LOW, d1);
		`CHK("frozen in idle", d0, d1)
		// Idle does not stop counting while suspend is clear
		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h00);
		rd(cawp_pkg::ADDR_COUNT_LOW, d0);
		repeat (16 * TICK - 2) @(negedge clk);
		rd(cawp_pkg::ADDR_COUNT_LOW, d1);
		`CHK("ticks in 192 cycles", 8'h10, 8'(d1 - d0))
		`CHK("ticks while idle", 1'b1, d1 != d0)
		cpu_idle = 1'b0;
		$display("test count source done");

		wr(cawp_pkg::ADDR_MODULE_MODE, 8'hcb);
		wr(cawp_pkg::ADDR_COMPARE_LOW, 8'hc0);
		rd(cawp_pkg::ADDR_MODULE_MODE, d0);
		`CHK("enable after low", 8'h8b, d0)
		wr(cawp_pkg::ADDR_COMPARE_HIGH, 8'hff);
		rd(cawp_pkg::ADDR_MODULE_MODE, d0);
		`CHK("enable after high", 8'hcb, d0)
		set_count(8'hf0);
		repeat (300) @(negedge clk);
		rd(cawp_pkg::ADDR_STATUS, d0);
		`CHK("overflow flag only", 8'h80, d0)
		`CHK("overflow irq masked", 1'b0, overflow_irq)
		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h01);
		repeat (2) @(negedge clk);
		`CHK("overflow irq enabled", 1'b1, overflow_irq)
		$display("test compare write done");

		set_count(8'hb0);
		wait_pin(1'b1, 400);
		wait_pin(1'b0, 1000);
		repeat (2) @(negedge clk);
		`CHK("high time", 64 * TICK, high_len)
		`CHK("match irq", 1'b1, match_irq)
		wr(cawp_pkg::ADDR_STATUS, 8'h00);
		repeat (2) @(negedge clk);
		`CHK("match irq cleared", 1'b0, match_irq)
		$display("test wide pwm done");

		r0 = rises;
		wr(cawp_pkg::ADDR_MODULE_MODE, 8'h4b);
		set_count(8'hb0);
		repeat (400) @(negedge clk);
		`CHK("no rise without wide", r0, rises)
		wr(cawp_pkg::ADDR_MODULE_MODE, 8'hcb);
		wr(cawp_pkg::ADDR_COMPARE_LOW, 8'hc0);
		set_count(8'hb0);
		repeat (400) @(negedge clk);
		`CHK("no rise when disabled", r0, rises)
		`CHK("pin low when disabled", 1'b0, pwm_output_pin)
		$display("test disable done");

		wr(cawp_pkg::ADDR_COMPARE_LOW, 8'h00);
		wr(cawp_pkg::ADDR_COMPARE_HIGH, 8'h00);
		set_count(8'hf0);
		wait_pin(1'b1, 400);
		r0 = falls;
		repeat (300) @(negedge clk);
		`CHK("full duty no fall", r0, falls)
		`CHK("full duty high", 1'b1, pwm_output_pin)
		$display("test full duty done");

		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h60);
		rd(cawp_pkg::ADDR_COUNTER_MODE, d0);
		`CHK("lock set", 8'h60, d0)
		wr(cawp_pkg::ADDR_COUNTER_MODE, 8'h00);
		rd(cawp_pkg::ADDR_COUNTER_MODE, d0);
		`CHK("lock holds select", 8'h60, d0)
		`CHK("watchdog while locked", 1'b1, watchdog_active)
		// Only a reset frees the lock
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		rd(cawp_pkg::ADDR_COUNTER_MODE, d0);
		`CHK("mode after reset", cawp_pkg::CM_RESET, d0)
		$display("test watchdog lock done");
		final_report();
	end
endmodule : tb_cawp_top
